/* inc/txbl_pkg.sv */
// Constants and types for the transmit buffer load port
// Overview of operation
// - Command 0011 loads bus data at phase 2 into buffer bits 5..8.
// - During the upper-half load, status nibble is driven to the processor.
// - Command 1001 loads bus data at phase 2 into buffer bits 1..4.
// - During the lower-half load, quality nibble is driven to the processor.
// - Lower-half load marks the buffer full.
// - Full buffer moves through the two-entry buffer to an idle shift register, then shifts out LSB first.
// - Load path works only in formatted character mode.
package txbl_pkg;
    localparam logic [3:0] CMD_LOAD_UPPER = 4'h3;
    localparam logic [3:0] CMD_LOAD_LOWER = 4'h9;
    localparam int CLOCK_HZ = 10_000_000;
    localparam int BIT_RATE_HZ = 1200;
    localparam int BIT_CYCLES = CLOCK_HZ / BIT_RATE_HZ;
    localparam logic [13:0] BIT_CYCLES_M1 = 14'(BIT_CYCLES - 1);
    localparam logic [7:0] BUF_RESET = 8'h00;
    localparam logic [3:0] BIT_COUNT_LAST = 4'h7;

    typedef struct packed {
        logic strobe;
        logic [3:0] command;
        logic [3:0] data;
    } txbl_cmd_t;

    typedef enum logic [1:0] {
        TXBL_IDLE = 2'b00,
        TXBL_SHIFT = 2'b01
    } txbl_state_t;
endpackage

/* rtl/txbl_fifo.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module txbl_fifo import txbl_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    logic [7:0] mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count_q != 2'h2;
    assign out_valid = count_q != 2'h0;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clock) begin
        if (srst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    a_fifo_no_over: assert property (@(posedge clock) disable iff (srst)
        count_q == 2'h2 && !pop |=> count_q == 2'h2 && out_data == $past(out_data))
        else $error("buffer accepted a word while full");
endmodule

/* rtl/txbl_top.sv */
// Transmit buffer load port with shift register
`timescale 1ns/1ns
module txbl_top import txbl_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Processor bus at phase 2 (pins)
    input wire logic load_strobe,
    input wire logic [3:0] load_command,
    input wire logic [3:0] bus_data_in,
    output logic [3:0] bus_data_out,
    output logic bus_data_oe_n,
    // Nibbles returned to the accumulator
    input wire logic [3:0] status_word,
    input wire logic [3:0] quality_word,
    // Mode
    input wire logic char_mode,
    // Serial side
    output logic serial_out,
    output logic shift_busy,
    output logic buffer_full
);
    // ------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------
    txbl_cmd_t cmd_s1_q;
    txbl_cmd_t cmd_s2_q;
    logic strobe_d3_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            cmd_s1_q <= '0;
            cmd_s2_q <= '0;
            strobe_d3_q <= 1'b0;
        end else begin
            cmd_s1_q <= '{load_strobe, load_command, bus_data_in};
            cmd_s2_q <= cmd_s1_q;
            strobe_d3_q <= cmd_s2_q.strobe;
        end
    end

    // ------------------------------------------------
    // Command decode
    // ------------------------------------------------
    wire phase2_edge = cmd_s2_q.strobe && !strobe_d3_q;
    wire is_upper = phase2_edge && cmd_s2_q.command == CMD_LOAD_UPPER && char_mode;
    wire is_lower = phase2_edge && cmd_s2_q.command == CMD_LOAD_LOWER && char_mode;
    wire mode_ok_upper = cmd_s2_q.strobe && cmd_s2_q.command == CMD_LOAD_UPPER && char_mode;
    wire mode_ok_lower = cmd_s2_q.strobe && cmd_s2_q.command == CMD_LOAD_LOWER && char_mode;

    // ------------------------------------------------
    // Answer nibble to the accumulator
    // ------------------------------------------------
    logic [3:0] out_q;
    logic oe_n_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            out_q <= 4'h0;
            oe_n_q <= 1'b1;
        end else begin
            out_q <= mode_ok_upper ? status_word : quality_word;
            oe_n_q <= !(mode_ok_upper || mode_ok_lower);
        end
    end
    assign bus_data_out = out_q;
    assign bus_data_oe_n = oe_n_q;

    // ------------------------------------------------
    // Holding buffer and full flag
    // ------------------------------------------------
    logic [7:0] hold_q;
    logic full_q;
    logic fifo_ready;
    wire take = full_q && fifo_ready;
    always_ff @(posedge clock) begin
        if (srst) begin
            hold_q <= BUF_RESET;
            full_q <= 1'b0;
        end else begin
            if (is_upper) begin
                hold_q[7:4] <= cmd_s2_q.data;
            end
            if (is_lower) begin
                hold_q[3:0] <= cmd_s2_q.data;
            end
            // Set wins over the transfer clear
            if (is_lower) begin
                full_q <= 1'b1;
            end else if (take) begin
                full_q <= 1'b0;
            end
        end
    end
    assign buffer_full = full_q;

    logic fifo_valid;
    logic [7:0] fifo_data;
    logic shift_ready;
    txbl_fifo u_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(full_q),
        .in_ready(fifo_ready),
        .in_data(hold_q),
        .out_valid(fifo_valid),
        .out_ready(shift_ready),
        .out_data(fifo_data)
    );

    // ------------------------------------------------
    // Shift register, bit-rate enable
    // ------------------------------------------------
    txbl_state_t state_q;
    logic [7:0] shreg_q;
    logic [2:0] nbit_q;
    logic [13:0] div_q;
    wire bit_tick = div_q == BIT_CYCLES_M1;
    assign shift_ready = state_q == TXBL_IDLE;
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= TXBL_IDLE;
            shreg_q <= 8'hff;
            nbit_q <= 3'h0;
            div_q <= 14'h0;
        end else begin
            div_q <= bit_tick ? 14'h0 : div_q + 14'h1;
            unique case (state_q)
                TXBL_IDLE: begin
                    if (fifo_valid) begin
                        shreg_q <= fifo_data;
                        nbit_q <= 3'h0;
                        div_q <= 14'h0;
                        state_q <= TXBL_SHIFT;
                    end
                end
                TXBL_SHIFT: begin
                    if (bit_tick) begin
                        shreg_q <= {1'b1, shreg_q[7:1]};
                        nbit_q <= nbit_q + 3'h1;
                        if ({1'b0, nbit_q} == BIT_COUNT_LAST) begin
                            state_q <= TXBL_IDLE;
                        end
                    end
                end
            endcase
        end
    end
    // Straight from the register: ones refill it, so the line idles high
    assign serial_out = shreg_q[0];
    assign shift_busy = state_q == TXBL_SHIFT;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    a_upper_load: assert property (@(posedge clock) disable iff (srst)
        is_upper |=> hold_q[7:4] == $past(cmd_s2_q.data))
        else $error("upper half not loaded");
    a_lower_load: assert property (@(posedge clock) disable iff (srst)
        is_lower |=> hold_q[3:0] == $past(cmd_s2_q.data))
        else $error("lower half not loaded");
    a_status_drive: assert property (@(posedge clock) disable iff (srst)
        mode_ok_upper |=> !bus_data_oe_n && bus_data_out == $past(status_word))
        else $error("status nibble not driven");
    a_quality_drive: assert property (@(posedge clock) disable iff (srst)
        mode_ok_lower |=> !bus_data_oe_n && bus_data_out == $past(quality_word))
        else $error("quality nibble not driven");
    a_full_set: assert property (@(posedge clock) disable iff (srst)
        is_lower |=> buffer_full)
        else $error("full not set by lower load");
    a_full_clear: assert property (@(posedge clock) disable iff (srst)
        take && !is_lower |=> !buffer_full)
        else $error("full not cleared on transfer");
    a_mode_gate: assert property (@(posedge clock) disable iff (srst)
        !char_mode && !buffer_full |=> !buffer_full)
        else $error("load accepted outside character mode");
    sequence s_start;
        shift_ready && fifo_valid;
    endsequence
    sequence s_first_bit;
        shift_busy && serial_out == $past(fifo_data[0]);
    endsequence
    a_shift_start: assert property (@(posedge clock) disable iff (srst)
        s_start |=> s_first_bit)
        else $error("shift did not start with lsb");
    a_start_load: assert property (@(posedge clock) disable iff (srst)
        s_start |=> shreg_q == $past(fifo_data))
        else $error("shift register not loaded in parallel");
    a_oe_release: assert property (@(posedge clock) disable iff (srst)
        !cmd_s2_q.strobe |=> bus_data_oe_n)
        else $error("bus driven without a command");
    a_mode_no_drive: assert property (@(posedge clock) disable iff (srst)
        !char_mode |=> bus_data_oe_n)
        else $error("bus driven outside character mode");
    a_upper_keeps_low: assert property (@(posedge clock) disable iff (srst)
        is_upper |=> $stable(hold_q[3:0]))
        else $error("upper load disturbed the lower half");
    a_lower_keeps_high: assert property (@(posedge clock) disable iff (srst)
        is_lower |=> $stable(hold_q[7:4]))
        else $error("lower load disturbed the upper half");
    a_full_only_lower: assert property (@(posedge clock) disable iff (srst)
        !is_lower && !buffer_full |=> !buffer_full)
        else $error("full set without a lower load");
    a_full_hold: assert property (@(posedge clock) disable iff (srst)
        buffer_full && !fifo_ready |=> buffer_full)
        else $error("full dropped while no room");
    a_take_push: assert property (@(posedge clock) disable iff (srst)
        take |=> fifo_valid)
        else $error("transferred word not buffered");
    a_idle_line: assert property (@(posedge clock) disable iff (srst)
        !shift_busy |-> serial_out)
        else $error("line not high while idle");
    a_bit_hold: assert property (@(posedge clock) disable iff (srst)
        shift_busy && !bit_tick |=> $stable(serial_out))
        else $error("serial bit changed within its bit time");
    // A bit time ends either mid-character or on the eighth bit
    sequence s_tick_mid;
        shift_busy && bit_tick && nbit_q != 3'h7;
    endsequence
    sequence s_tick_last;
        shift_busy && bit_tick && nbit_q == 3'h7;
    endsequence
    a_bit_step: assert property (@(posedge clock) disable iff (srst)
        s_tick_mid |=> shift_busy && serial_out == $past(shreg_q[1]))
        else $error("next bit not shifted out");
    a_last_bit: assert property (@(posedge clock) disable iff (srst)
        s_tick_last |=> !shift_busy)
        else $error("shift did not stop after eight bits");
endmodule

/* tb/txbl_cpu_model.sv */
// Processor model issuing load commands on the phase-2 bus
`timescale 1ns/1ns
module txbl_cpu_model (
    // Clock
    input wire logic clock,
    // Bus toward the block
    output logic load_strobe,
    output logic [3:0] load_command,
    output logic [3:0] bus_data_in,
    input wire logic [3:0] bus_data_out,
    input wire logic bus_data_oe_n
);
    initial begin
        load_strobe = 1'b0;
        load_command = 4'h0;
        bus_data_in = 4'h0;
    end
    // Strobe held five cycles so the synchronised answer is up when sampled
    task automatic issue(input logic [3:0] cmd, input logic [3:0] data, input int gap,
                         output logic [3:0] ans, output logic oe_n);
        @(posedge clock) #1;
        load_command = cmd;
        bus_data_in = data;
        load_strobe = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        ans = bus_data_out;
        oe_n = bus_data_oe_n;
        @(posedge clock) #1;
        load_strobe = 1'b0;
        // Released bus shows the inverse, never a stale value
        bus_data_in = ~data;
        load_command = ~cmd;
        repeat (gap) @(posedge clock);
        #1;
    endtask
endmodule

/* tb/tb_txbl_top.sv */
// Self-checking bench for the transmit buffer load port
`timescale 1ns/1ns
module tb_txbl_top import txbl_pkg::*; ;
    logic clock, srst, char_mode, bus_data_oe_n, serial_out, shift_busy, buffer_full;
    logic load_strobe, full_seen, oe_n;
    logic [3:0] load_command, bus_data_in, bus_data_out, status_word, quality_word, ans;
    logic [31:0] lfsr_state;
    logic [7:0] exp_q[$];
    int n_fail, total_checks, cycles, k;
    txbl_top uut (.clock(clock), .srst(srst), .load_strobe(load_strobe), .load_command(load_command),
        .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .status_word(status_word), .quality_word(quality_word), .char_mode(char_mode),
        .serial_out(serial_out), .shift_busy(shift_busy), .buffer_full(buffer_full));
    txbl_cpu_model cpu (.clock(clock), .load_strobe(load_strobe), .load_command(load_command),
        .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        if (buffer_full === 1'b1) full_seen = 1'b1;
        cycles++;
        if (cycles == 95000) begin
            n_fail++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state[7:0];
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send_char(input logic [7:0] ch, input int gap, input logic full_exp);
        full_seen = 1'b0;
        cpu.issue(CMD_LOAD_UPPER, ch[7:4], gap, ans, oe_n);
        check("upper oe_n", 8'h00, 8'(oe_n));
        check("status nibble", 8'(status_word), 8'(ans));
        check("full after upper", 8'h00, 8'(full_seen));
        cpu.issue(CMD_LOAD_LOWER, ch[3:0], gap, ans, oe_n);
        check("lower oe_n", 8'h00, 8'(oe_n));
        check("quality nibble", 8'(quality_word), 8'(ans));
        check("full after lower", 8'h01, 8'(full_seen));
        check("full held", 8'(full_exp), 8'(buffer_full));
        exp_q.push_back(ch);
    endtask
    task automatic check_serial();
        logic [7:0] exp;
        exp = exp_q.pop_front();
        wait (shift_busy === 1'b1);
        repeat (BIT_CYCLES / 2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            #1 check("serial bit", 8'(exp[i]), 8'(serial_out));
            check("busy", 8'h01, 8'(shift_busy));
            repeat (BIT_CYCLES) @(posedge clock);
        end
        $display("test serial done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        char_mode = 1'b0;
        status_word = 4'h0;
        quality_word = 4'h0;
        lfsr_state = 32'd87982;
        repeat (20) @(posedge clock);
        #1 srst = 1'b0;
        check("idle serial", 8'h01, 8'(serial_out));
        full_seen = 1'b0;
        cpu.issue(CMD_LOAD_LOWER, 4'h5, 3, ans, oe_n);
        check("inhibited oe_n", 8'h01, 8'(oe_n));
        check("inhibited full", 8'h00, 8'(full_seen));
        char_mode = 1'b1;
        cpu.issue(4'h5, 4'ha, 3, ans, oe_n);
        check("unknown cmd oe_n", 8'h01, 8'(oe_n));
        check("unknown cmd full", 8'h00, 8'(full_seen));
        $display("test refusals done");
        status_word = 4'(rnd());
        quality_word = 4'(rnd());
        send_char(rnd(), 3, 1'b0);
        // Later characters fill the two-entry buffer, the last one must wait
        fork
            check_serial();
            for (k = 0; k < 3; k++) send_char(rnd(), 3 + 7 * k, k == 2);
        join
        $display("test fill done");
        end_sim();
    end
endmodule
